// File: core/bfs_pkg.sv
// Shared constants and types of the bit, flag and shift unit.
// Assumes a 32-bit APB slave decoding byte addresses in one 256-byte window.
package bfs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] BFS_CMD_OFF = 8'h00;
  localparam logic [7:0] BFS_DEST_OFF = 8'h04;
  localparam logic [7:0] BFS_SRC_OFF = 8'h08;
  localparam logic [7:0] BFS_STAT_OFF = 8'h0c;
  localparam logic [7:0] BFS_IO_OFF = 8'h10;
  localparam logic [7:0] BFS_STATE_OFF = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BFS_CMD_OP_LSB = 0;
  localparam int BFS_CMD_BIT_LSB = 8;
  localparam int BFS_BUSY_POS = 0;
  localparam logic [7:0] BFS_DEST_RST = 8'h00;
  localparam logic [7:0] BFS_SRC_RST = 8'h00;
  localparam logic [7:0] BFS_STAT_RST = 8'h00;
  localparam logic [7:0] BFS_IO_RST = 8'hff;

  // Status register flag positions, bit 7 down to bit 0
  localparam logic [2:0] BFS_FLAG_I = 3'h7;
  localparam logic [2:0] BFS_FLAG_T = 3'h6;
  localparam logic [2:0] BFS_FLAG_H = 3'h5;
  localparam logic [2:0] BFS_FLAG_S = 3'h4;
  localparam logic [2:0] BFS_FLAG_V = 3'h3;
  localparam logic [2:0] BFS_FLAG_N = 3'h2;
  localparam logic [2:0] BFS_FLAG_Z = 3'h1;
  localparam logic [2:0] BFS_FLAG_C = 3'h0;

  // ----------------------------------------------------------------
  // Operation codes written into the command register
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    BFS_NOP_OP = 5'h00, BFS_SHIFT_LEFT_LOGICAL_OP = 5'h01, BFS_SHIFT_RIGHT_LOGICAL_OP = 5'h02,
    BFS_ROTATE_LEFT_CARRY_OP = 5'h03, BFS_ROTATE_RIGHT_CARRY_OP = 5'h04,
    BFS_SHIFT_RIGHT_ARITH_OP = 5'h05, BFS_NIBBLE_SWAP_OP = 5'h06,
    BFS_STATUS_BIT_SET_OP = 5'h07, BFS_STATUS_BIT_CLEAR_OP = 5'h08,
    BFS_REG_BIT_TO_TRANSFER_OP = 5'h09, BFS_TRANSFER_TO_REG_BIT_OP = 5'h0a,
    BFS_IO_BIT_CLEAR_OP = 5'h0b, BFS_CARRY_SET_OP = 5'h0c, BFS_CARRY_CLEAR_OP = 5'h0d,
    BFS_NEGATIVE_FLAG_SET_OP = 5'h0e, BFS_NEGATIVE_FLAG_CLEAR_OP = 5'h0f,
    BFS_ZERO_FLAG_SET_OP = 5'h10, BFS_ZERO_FLAG_CLEAR_OP = 5'h11,
    BFS_IRQ_GLOBAL_ON_OP = 5'h12, BFS_IRQ_GLOBAL_OFF_OP = 5'h13,
    BFS_SIGN_FLAG_SET_OP = 5'h14, BFS_SIGN_FLAG_CLEAR_OP = 5'h15,
    BFS_OVERFLOW_FLAG_SET_OP = 5'h16, BFS_OVERFLOW_FLAG_CLEAR_OP = 5'h17,
    BFS_TRANSFER_FLAG_SET_OP = 5'h18, BFS_HALF_CARRY_CLEAR_OP = 5'h19,
    BFS_SLEEP_OP = 5'h1a, BFS_WATCHDOG_RESTART_OP = 5'h1b
  } bfs_op_t;

  // Latched command: operation and bit selector
  typedef struct packed {
    logic [2:0] bit_sel;
    logic [4:0] op;
  } bfs_cmd_t;

  localparam bfs_cmd_t BFS_CMD_RST = '{bit_sel: 3'h0, op: 5'h00};

  // APB request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } bfs_apb_req_t;

  // Execution states
  typedef enum logic [1:0] {BFS_ST_IDLE, BFS_ST_RUN, BFS_ST_IO2} bfs_state_t;

endpackage

// File: core/bfs_shift_unit.sv
// Shift, rotate and swap datapath with flag results.
// Assumes the caller keeps H, I and T itself and chooses when to use the flags.
`timescale 1ns/1ns
module bfs_shift_unit (
  input wire logic [4:0] op,
  input wire logic [7:0] din,
  input wire logic cin,
  output logic [7:0] dout,
  output logic cout,
  output logic n_flag,
  output logic z_flag,
  output logic v_flag,
  output logic s_flag
);

  // ----------------------------------------------------------------
  // Result and carry selection
  // ----------------------------------------------------------------
  wire logic is_shl = (op == bfs_pkg::BFS_SHIFT_LEFT_LOGICAL_OP);
  wire logic is_shr = (op == bfs_pkg::BFS_SHIFT_RIGHT_LOGICAL_OP);
  wire logic is_rotl = (op == bfs_pkg::BFS_ROTATE_LEFT_CARRY_OP);
  wire logic is_rotr = (op == bfs_pkg::BFS_ROTATE_RIGHT_CARRY_OP);
  wire logic is_sra = (op == bfs_pkg::BFS_SHIFT_RIGHT_ARITH_OP);

  // Shifts and rotates; anything else is the nibble swap
  assign dout = is_shl ? {din[6:0], 1'b0} :
                is_shr ? {1'b0, din[7:1]} :
                is_rotl ? {din[6:0], cin} :
                is_rotr ? {cin, din[7:1]} :
                is_sra ? {din[7], din[7:1]} :
                {din[3:0], din[7:4]};
  assign cout = (is_shl | is_rotl) ? din[7] : din[0];

  // Derived flags from the result
  assign n_flag = dout[7];
  assign z_flag = (dout == 8'h00);
  assign v_flag = n_flag ^ cout;
  assign s_flag = n_flag ^ v_flag;

endmodule // bfs_shift_unit

// File: core/bfs_core.sv
// Bit, flag and shift execution unit with an APB register front end.
// Assumes an APB master on pclk; sleep and watchdog logic sit outside.
//
// Notes on behaviour
// - Left logical shift, zero in, flags, one cycle
// - Right logical shift, zero in, flags, one cycle
// - Rotate left through carry, flags updated
// - Rotate right through carry, flags updated
// - Arithmetic right shift keeps bit seven
// - Nibble swap, no flag change, one cycle
// - Set or clear one selected status bit
// - Copy selected source bit into T
// - Write T into selected destination bit
// - Clear one I/O bit over two cycles
// - Force C or N, touching nothing else
// - Force Z to one or zero
// - Set or clear global interrupt enable
// - Force S to one or zero
// - Force V to one or zero
// - Set T to one, nothing else
// - Clear half carry flag H
// - Sleep: one cycle, no flags, request out
// - Watchdog restart: one cycle, pulse out
`timescale 1ns/1ns
module bfs_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] status_flags,
  output logic [7:0] io_bits,
  output logic sleep_req,
  output logic wdt_restart
);

  // ----------------------------------------------------------------
  // Request bundle and decode
  // ----------------------------------------------------------------
  bfs_pkg::bfs_apb_req_t req;
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};

  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  bfs_pkg::bfs_state_t state_reg;
  bfs_pkg::bfs_state_t state_next;
  bfs_pkg::bfs_cmd_t cmd_reg;
  bfs_pkg::bfs_cmd_t cmd_next;
  logic [7:0] dest_reg;
  logic [7:0] dest_next;
  logic [7:0] src_reg;
  logic [7:0] src_next;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [7:0] io_reg;
  logic [7:0] io_next;
  logic sleep_reg;
  logic wdt_reg;

  // Address match, shared by read mux and write strobes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  wire logic idle = (state_reg == bfs_pkg::BFS_ST_IDLE);
  wire logic access = req.sel & req.enable;
  wire logic done = access & pready_reg;
  wire logic wr_en = done & req.write;
  wire logic mapped = hit(req.addr, bfs_pkg::BFS_CMD_OFF) | hit(req.addr, bfs_pkg::BFS_DEST_OFF) |
                      hit(req.addr, bfs_pkg::BFS_SRC_OFF) | hit(req.addr, bfs_pkg::BFS_STAT_OFF) |
                      hit(req.addr, bfs_pkg::BFS_IO_OFF) | hit(req.addr, bfs_pkg::BFS_STATE_OFF);
  wire logic wr_cmd = wr_en & hit(req.addr, bfs_pkg::BFS_CMD_OFF);
  wire logic wr_dest = wr_en & hit(req.addr, bfs_pkg::BFS_DEST_OFF);
  wire logic wr_src = wr_en & hit(req.addr, bfs_pkg::BFS_SRC_OFF);
  wire logic wr_stat = wr_en & hit(req.addr, bfs_pkg::BFS_STAT_OFF);
  wire logic wr_io = wr_en & hit(req.addr, bfs_pkg::BFS_IO_OFF);

  // ----------------------------------------------------------------
  // APB answer: one wait state, held off while an operation runs
  // ----------------------------------------------------------------
  // Stalling on busy keeps software writes apart from execution
  assign pready_next = access & ~pready_reg & idle;
  assign pslverr_next = access & ~pready_reg & idle & ~mapped;

  // Read mux; unmapped addresses read zero
  wire logic [31:0] rd_data =
    hit(req.addr, bfs_pkg::BFS_CMD_OFF) ? {21'h000000, cmd_reg.bit_sel, 3'h0, cmd_reg.op} :
    hit(req.addr, bfs_pkg::BFS_DEST_OFF) ? {24'h000000, dest_reg} :
    hit(req.addr, bfs_pkg::BFS_SRC_OFF) ? {24'h000000, src_reg} :
    hit(req.addr, bfs_pkg::BFS_STAT_OFF) ? {24'h000000, stat_reg} :
    hit(req.addr, bfs_pkg::BFS_IO_OFF) ? {24'h000000, io_reg} :
    hit(req.addr, bfs_pkg::BFS_STATE_OFF) ? {31'h00000000, ~idle} : 32'h00000000;
  assign prdata_next = (pready_next & ~req.write) ? rd_data : prdata_reg;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  wire logic run = (state_reg == bfs_pkg::BFS_ST_RUN);
  wire logic is_io_clr = (cmd_reg.op == bfs_pkg::BFS_IO_BIT_CLEAR_OP);

  // A command write starts execution; the I/O bit clear needs a second cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bfs_pkg::BFS_ST_IDLE: begin
        if (wr_cmd) begin
          state_next = bfs_pkg::BFS_ST_RUN;
        end
      end
      bfs_pkg::BFS_ST_RUN: begin
        state_next = is_io_clr ? bfs_pkg::BFS_ST_IO2 : bfs_pkg::BFS_ST_IDLE;
      end
      bfs_pkg::BFS_ST_IO2: begin
        state_next = bfs_pkg::BFS_ST_IDLE;
      end
      default: begin
        state_next = bfs_pkg::BFS_ST_IDLE;
      end
    endcase
  end

  assign cmd_next = wr_cmd ? '{bit_sel: req.wdata[bfs_pkg::BFS_CMD_BIT_LSB +: 3],
                               op: req.wdata[bfs_pkg::BFS_CMD_OP_LSB +: 5]} : cmd_reg;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [7:0] sh_out;
  logic sh_c;
  logic sh_n;
  logic sh_z;
  logic sh_v;
  logic sh_s;

  bfs_shift_unit bfs_shift_unit_i (
    .op(cmd_reg.op),
    .din(dest_reg),
    .cin(stat_reg[bfs_pkg::BFS_FLAG_C]),
    .dout(sh_out),
    .cout(sh_c),
    .n_flag(sh_n),
    .z_flag(sh_z),
    .v_flag(sh_v),
    .s_flag(sh_s)
  );

  // Fixed-flag operations map to a status bit and a value
  wire logic [2:0] fix_idx =
    (cmd_reg.op == bfs_pkg::BFS_CARRY_SET_OP || cmd_reg.op == bfs_pkg::BFS_CARRY_CLEAR_OP) ?
      bfs_pkg::BFS_FLAG_C :
    (cmd_reg.op == bfs_pkg::BFS_NEGATIVE_FLAG_SET_OP || cmd_reg.op == bfs_pkg::BFS_NEGATIVE_FLAG_CLEAR_OP) ?
      bfs_pkg::BFS_FLAG_N :
    (cmd_reg.op == bfs_pkg::BFS_ZERO_FLAG_SET_OP || cmd_reg.op == bfs_pkg::BFS_ZERO_FLAG_CLEAR_OP) ?
      bfs_pkg::BFS_FLAG_Z :
    (cmd_reg.op == bfs_pkg::BFS_IRQ_GLOBAL_ON_OP || cmd_reg.op == bfs_pkg::BFS_IRQ_GLOBAL_OFF_OP) ?
      bfs_pkg::BFS_FLAG_I :
    (cmd_reg.op == bfs_pkg::BFS_SIGN_FLAG_SET_OP || cmd_reg.op == bfs_pkg::BFS_SIGN_FLAG_CLEAR_OP) ?
      bfs_pkg::BFS_FLAG_S :
    (cmd_reg.op == bfs_pkg::BFS_OVERFLOW_FLAG_SET_OP || cmd_reg.op == bfs_pkg::BFS_OVERFLOW_FLAG_CLEAR_OP) ?
      bfs_pkg::BFS_FLAG_V :
    (cmd_reg.op == bfs_pkg::BFS_TRANSFER_FLAG_SET_OP) ? bfs_pkg::BFS_FLAG_T :
    bfs_pkg::BFS_FLAG_H;
  // Set codes are the even ones of each pair, plus the T set
  wire logic fix_val = (cmd_reg.op == bfs_pkg::BFS_TRANSFER_FLAG_SET_OP) | ~cmd_reg.op[0];
  wire logic is_fix = (cmd_reg.op >= bfs_pkg::BFS_CARRY_SET_OP) &&
                      (cmd_reg.op <= bfs_pkg::BFS_HALF_CARRY_CLEAR_OP);
  wire logic is_shift = (cmd_reg.op >= bfs_pkg::BFS_SHIFT_LEFT_LOGICAL_OP) &&
                        (cmd_reg.op <= bfs_pkg::BFS_SHIFT_RIGHT_ARITH_OP);

  // Register next values: software writes only while idle, execution otherwise
  always_comb begin
    dest_next = dest_reg;
    stat_next = stat_reg;
    io_next = io_reg;
    src_next = wr_src ? req.wdata[7:0] : src_reg;
    if (wr_dest) begin
      dest_next = req.wdata[7:0];
    end
    if (wr_stat) begin
      stat_next = req.wdata[7:0];
    end
    if (wr_io) begin
      io_next = req.wdata[7:0];
    end
    if (run && is_shift) begin
      dest_next = sh_out;
      stat_next[bfs_pkg::BFS_FLAG_C] = sh_c;
      stat_next[bfs_pkg::BFS_FLAG_N] = sh_n;
      stat_next[bfs_pkg::BFS_FLAG_Z] = sh_z;
      stat_next[bfs_pkg::BFS_FLAG_V] = sh_v;
      stat_next[bfs_pkg::BFS_FLAG_S] = sh_s;
    end
    if (run && cmd_reg.op == bfs_pkg::BFS_NIBBLE_SWAP_OP) begin
      dest_next = sh_out;
    end
    if (run && cmd_reg.op == bfs_pkg::BFS_STATUS_BIT_SET_OP) begin
      stat_next[cmd_reg.bit_sel] = 1'b1;
    end
    if (run && cmd_reg.op == bfs_pkg::BFS_STATUS_BIT_CLEAR_OP) begin
      stat_next[cmd_reg.bit_sel] = 1'b0;
    end
    if (run && cmd_reg.op == bfs_pkg::BFS_REG_BIT_TO_TRANSFER_OP) begin
      stat_next[bfs_pkg::BFS_FLAG_T] = src_reg[cmd_reg.bit_sel];
    end
    if (run && cmd_reg.op == bfs_pkg::BFS_TRANSFER_TO_REG_BIT_OP) begin
      dest_next[cmd_reg.bit_sel] = stat_reg[bfs_pkg::BFS_FLAG_T];
    end
    if (run && is_fix) begin
      stat_next[fix_idx] = fix_val;
    end
    if (state_reg == bfs_pkg::BFS_ST_IO2) begin
      io_next[cmd_reg.bit_sel] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // Control state and command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= bfs_pkg::BFS_ST_IDLE;
      cmd_reg <= bfs_pkg::BFS_CMD_RST;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
    end
  end

  // Operand, status and I/O registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dest_reg <= bfs_pkg::BFS_DEST_RST;
      src_reg <= bfs_pkg::BFS_SRC_RST;
      stat_reg <= bfs_pkg::BFS_STAT_RST;
      io_reg <= bfs_pkg::BFS_IO_RST;
    end else begin
      dest_reg <= dest_next;
      src_reg <= src_next;
      stat_reg <= stat_next;
      io_reg <= io_next;
    end
  end

  // One-cycle requests to the sleep and watchdog logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
      wdt_reg <= 1'b0;
    end else begin
      sleep_reg <= run & (cmd_reg.op == bfs_pkg::BFS_SLEEP_OP);
      wdt_reg <= run & (cmd_reg.op == bfs_pkg::BFS_WATCHDOG_RESTART_OP);
    end
  end

  // Outputs straight from flops
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  assign status_flags = stat_reg;
  assign io_bits = io_reg;
  assign sleep_req = sleep_reg;
  assign wdt_restart = wdt_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_run_op(logic [4:0] code);
    run && cmd_reg.op == code;
  endsequence

  sequence s_io_clr_start;
    run && is_io_clr;
  endsequence

  a_shl_result: assert property (s_run_op(bfs_pkg::BFS_SHIFT_LEFT_LOGICAL_OP) |=>
    dest_reg == {$past(dest_reg[6:0]), 1'b0} && stat_reg[0] == $past(dest_reg[7]))
    else $error("left shift result or carry wrong");

  a_shr_result: assert property (s_run_op(bfs_pkg::BFS_SHIFT_RIGHT_LOGICAL_OP) |=>
    dest_reg == {1'b0, $past(dest_reg[7:1])} && stat_reg[0] == $past(dest_reg[0]))
    else $error("right shift result or carry wrong");

  a_rotl_carry: assert property (s_run_op(bfs_pkg::BFS_ROTATE_LEFT_CARRY_OP) |=>
    dest_reg[0] == $past(stat_reg[0]) && stat_reg[0] == $past(dest_reg[7]))
    else $error("rotate left carry path wrong");

  a_rotr_carry: assert property (s_run_op(bfs_pkg::BFS_ROTATE_RIGHT_CARRY_OP) |=>
    dest_reg[7] == $past(stat_reg[0]) && stat_reg[0] == $past(dest_reg[0]))
    else $error("rotate right carry path wrong");

  a_sra_sign: assert property (s_run_op(bfs_pkg::BFS_SHIFT_RIGHT_ARITH_OP) |=>
    dest_reg == {$past(dest_reg[7]), $past(dest_reg[7:1])})
    else $error("arithmetic shift lost sign");

  a_swap_flags: assert property (s_run_op(bfs_pkg::BFS_NIBBLE_SWAP_OP) |=>
    dest_reg == {$past(dest_reg[3:0]), $past(dest_reg[7:4])} && $stable(stat_reg))
    else $error("nibble swap wrong or flags moved");

  a_shift_flags: assert property (run && is_shift |=>
    stat_reg[2] == dest_reg[7] && stat_reg[1] == (dest_reg == 8'h00) &&
    stat_reg[3] == (stat_reg[2] ^ stat_reg[0]) && stat_reg[4] == (stat_reg[2] ^ stat_reg[3]))
    else $error("shift flags inconsistent");

  a_bit_set: assert property (s_run_op(bfs_pkg::BFS_STATUS_BIT_SET_OP) |=>
    stat_reg == ($past(stat_reg) | (8'h01 << $past(cmd_reg.bit_sel))))
    else $error("status bit set touched other bits");

  a_t_store: assert property (s_run_op(bfs_pkg::BFS_REG_BIT_TO_TRANSFER_OP) |=>
    stat_reg[6] == $past(src_reg[cmd_reg.bit_sel]) && stat_reg[5:0] == $past(stat_reg[5:0]))
    else $error("transfer flag store wrong");

  a_t_load: assert property (s_run_op(bfs_pkg::BFS_TRANSFER_TO_REG_BIT_OP) |=>
    dest_reg[cmd_reg.bit_sel] == stat_reg[6] && $stable(stat_reg))
    else $error("transfer flag load wrong");

  a_io_clear_two: assert property (s_io_clr_start |=>
    state_reg == bfs_pkg::BFS_ST_IO2 ##1 (idle && io_reg[cmd_reg.bit_sel] == 1'b0 && $stable(stat_reg)))
    else $error("io bit clear not done in two cycles");

  a_fix_flag: assert property (run && is_fix |=>
    stat_reg[$past(fix_idx)] == $past(fix_val))
    else $error("fixed flag operation wrong");

  a_sleep_pulse: assert property (s_run_op(bfs_pkg::BFS_SLEEP_OP) |=>
    sleep_req && idle && $stable(stat_reg) ##1 !sleep_req)
    else $error("sleep request not a single pulse");

  a_wdt_pulse: assert property (s_run_op(bfs_pkg::BFS_WATCHDOG_RESTART_OP) |=>
    wdt_restart && $stable(stat_reg) ##1 !wdt_restart)
    else $error("watchdog restart not a single pulse");

  a_apb_answer: assert property (access && !pready && idle |=> pready ##1 !pready)
    else $error("bus answer not one wait state");

endmodule // bfs_core

// File: dv/bfs_core_test.sv
// Self-checking testbench of the bit, flag and shift unit, driven over APB.
// Assumes bfs_core and bfs_pkg are compiled first; one 50 MHz clock, async low reset.
`timescale 1ns/1ns
module bfs_core_test;
  // ----------------------------------------------------------------
  // Signals and expectation tables
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req, wdt_restart, er;
  logic [7:0] paddr, status_flags, io_bits;
  logic [31:0] pwdata, prdata, rd;
  int bad_count = 0;
  int samples_checked = 0;
  int n_sleep = 0;
  int n_wdt = 0;
  localparam logic [2:0] FB [6] = '{bfs_pkg::BFS_FLAG_C, bfs_pkg::BFS_FLAG_N, bfs_pkg::BFS_FLAG_Z,
                                   bfs_pkg::BFS_FLAG_I, bfs_pkg::BFS_FLAG_S, bfs_pkg::BFS_FLAG_V};
  localparam logic [7:0] DV [4] = '{8'h81, 8'h00, 8'h40, 8'h01};

  bfs_core bfs_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_flags(status_flags), .io_bits(io_bits), .sleep_req(sleep_req), .wdt_restart(wdt_restart));

  // Clock and pulse-width accounting
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_sleep += (sleep_req === 1'b1);
    n_wdt += (wdt_restart === 1'b1);
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; waits for pready (the watchdog ends a hang), then checks the single wait state
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    n = 0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h2, 32'(n));
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Expected {status, dest} after one operation
  function automatic logic [15:0] expect_op(input logic [4:0] op, input logic [2:0] b, input logic [7:0] d,
                                            input logic [7:0] s, input logic [7:0] src);
    logic [7:0] r, ns;
    logic c;
    r = d;
    ns = s;
    c = s[0];
    case (op)
      5'h01: {c, r} = {d, 1'b0};
      5'h02: {r, c} = {1'b0, d};
      5'h03: {c, r} = {d, s[0]};
      5'h04: {r, c} = {s[0], d};
      5'h05: {r, c} = {d[7], d};
      5'h06: r = {d[3:0], d[7:4]};
      5'h07: ns[b] = 1'b1;
      5'h08: ns[b] = 1'b0;
      5'h09: ns[6] = src[b];
      5'h0a: r[b] = s[6];
      5'h18: ns[6] = 1'b1;
      5'h19: ns[5] = 1'b0;
      default: if (op >= 5'h0c && op <= 5'h17) ns[FB[(op - 5'h0c) >> 1]] = ~op[0];
    endcase
    if (op >= 5'h01 && op <= 5'h05) begin
      ns[0] = c;
      ns[2] = r[7];
      ns[1] = (r == 8'h00);
      ns[3] = r[7] ^ c;
      ns[4] = ns[2] ^ ns[3];
    end
    return {ns, r};
  endfunction

  // Loads operands, issues one command, checks flags one cycle later and the result
  task try_op(input logic [4:0] op, input logic [2:0] b, input logic [7:0] d, input logic [7:0] s,
              input logic [7:0] src);
    logic [15:0] e;
    e = expect_op(op, b, d, s, src);
    apb(1'b1, bfs_pkg::BFS_STAT_OFF, {24'h0, s});
    apb(1'b1, bfs_pkg::BFS_DEST_OFF, {24'h0, d});
    apb(1'b1, bfs_pkg::BFS_SRC_OFF, {24'h0, src});
    apb(1'b1, bfs_pkg::BFS_CMD_OFF, {21'h0, b, 3'h0, op});
    @(posedge pclk);
    #1;
    chk("status_flags", {24'h0, e[15:8]}, {24'h0, status_flags});
    chk("sleep_req", {31'h0, op == 5'h1a}, {31'h0, sleep_req});
    chk("wdt_restart", {31'h0, op == 5'h1b}, {31'h0, wdt_restart});
    apb(1'b0, bfs_pkg::BFS_DEST_OFF, 32'h0);
    chk("dest", {24'h0, e[7:0]}, rd);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task s_reset;
    chk("status reset", 32'h0, {24'h0, status_flags});
    chk("io reset", {24'h0, bfs_pkg::BFS_IO_RST}, {24'h0, io_bits});
    apb(1'b0, bfs_pkg::BFS_STAT_OFF, 32'h0);
    chk("status reg", {24'h0, bfs_pkg::BFS_STAT_RST}, rd);
    apb(1'b0, bfs_pkg::BFS_IO_OFF, 32'h0);
    chk("io reg", {24'h0, bfs_pkg::BFS_IO_RST}, rd);
    apb(1'b0, bfs_pkg::BFS_STATE_OFF, 32'h0);
    chk("state reg", 32'h0, rd);
  endtask

  // Clears bits 0 then 7; the bit drops only at the end of the second cycle
  task s_io;
    logic [7:0] e;
    e = 8'hff;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, bfs_pkg::BFS_CMD_OFF, {21'h0, 3'(i * 7), 3'h0, 5'h0b});
      @(posedge pclk);
      #1;
      chk("io first cycle", {24'h0, e}, {24'h0, io_bits});
      e[i * 7] = 1'b0;
      @(posedge pclk);
      #1;
      chk("io second cycle", {24'h0, e}, {24'h0, io_bits});
      chk("flags kept", 32'h0, {24'h0, status_flags});
      apb(1'b0, bfs_pkg::BFS_IO_OFF, 32'h0);
      chk("io reg", {24'h0, e}, rd);
    end
  endtask

  task s_shift;
    for (int o = 1; o <= 6; o++)
      for (int i = 0; i < 4; i++)
        for (int c = 0; c < 2; c++)
          try_op(5'(o), 3'h0, DV[i], 8'hea | 8'(c), 8'h00);
  endtask

  task s_bits;
    for (int b = 0; b < 8; b++) begin
      try_op(5'h07, 3'(b), 8'h00, 8'h00, 8'h00);
      try_op(5'h08, 3'(b), 8'h00, 8'hff, 8'h00);
      try_op(5'h09, 3'(b), 8'h00, 8'h00, 8'h01 << b);
      try_op(5'h09, 3'(b), 8'hff, 8'hff, ~(8'h01 << b));
      try_op(5'h0a, 3'(b), 8'h00, 8'h40, 8'h00);
      try_op(5'h0a, 3'(b), 8'hff, 8'hbf, 8'h00);
    end
  endtask

  // Every flag, control and spare code from both all-zero and all-one status
  task s_flags;
    for (int o = 11; o <= 32; o++) begin
      try_op(5'(o), 3'h0, 8'h3c, 8'h00, 8'h00);
      try_op(5'(o), 3'h0, 8'h3c, 8'hff, 8'h00);
    end
    chk("sleep pulses", 32'h2, 32'(n_sleep));
    chk("watchdog pulses", 32'h2, 32'(n_wdt));
  endtask

  task s_bus;
    apb(1'b1, 8'h40, 32'hffffffff);
    chk("unmapped write err", 32'h1, {31'h0, er});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped read err", 32'h1, {31'h0, er});
    chk("unmapped read data", 32'h0, rd);
    apb(1'b0, bfs_pkg::BFS_STATE_OFF, 32'h0);
    chk("mapped err", 32'h0, {31'h0, er});
    chk("idle state", 32'h0, rd);
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    s_reset;
    s_io;
    s_shift;
    s_bits;
    s_flags;
    s_bus;
    conclude;
  end

  initial begin
    #400000;
    bad_count++;
    conclude;
  end
endmodule // bfs_core_test
